/* File: rtl/vci_event_select.sv */
`timescale 1ns/100ps
// Holds one client's configured event and turns strobes into a fire pulse
module vci_event_select #(
   parameter bit DEFAULT_RX = 1'b1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cfg_load,
   input wire vci_pkg::vci_event_sel_t cfg_sel,
   input wire logic eof_rx,
   input wire logic eof_tx,
   input wire logic alt,
   output logic fire,
   output logic is_default
);
   import vci_pkg::*;

   vci_event_sel_t sel_reg; // Last configured event
   vci_event_sel_t sel_next;

   // Newest descriptor replaces the old choice
   always_comb begin
      sel_next = cfg_load ? cfg_sel : sel_reg;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_reg <= EV_DEFAULT;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // Decode the chosen event; an illegal code fires nothing
   always_comb begin
      is_default = (sel_reg == EV_DEFAULT);
      unique case (sel_reg)
         EV_DEFAULT: fire = DEFAULT_RX ? eof_rx : eof_tx;
         EV_EOF_RX: fire = eof_rx;
         EV_EOF_TX: fire = eof_tx;
         EV_ALT: fire = alt;
         default: fire = 1'b0;
      endcase
   end

endmodule : vci_event_select

/* File: rtl/vci_irq_status_mask.sv */
`timescale 1ns/100ps
// Client interrupt status and enable registers behind an AXI4-Lite slave
module vci_irq_status_mask (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [vci_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [vci_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [vci_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [vci_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [vci_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire vci_pkg::vci_descriptor_t descriptor,
   input wire vci_pkg::vci_events_t client_events,
   output logic shared_irq_line_three
);
   import vci_pkg::*;

   // Register select codes
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_STAT = 2'h1;
   localparam logic [1:0] SEL_EN = 2'h2;

   // Address decode, shared by the read and write paths
   function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] addr);
      logic [1:0] hit;
      hit = SEL_NONE;
      if (addr[ADDR_W-1:2] == STAT_OFFSET[ADDR_W-1:2]) begin
         hit = SEL_STAT;
      end else if (addr[ADDR_W-1:2] == EN_OFFSET[ADDR_W-1:2]) begin
         hit = SEL_EN;
      end
      return hit;
   endfunction : reg_select

   // Expand byte strobes into a bit mask
   function automatic logic [DATA_W-1:0] strb_mask(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < STRB_W; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction : strb_mask

   // Write channel holding state
   logic aw_full_reg, aw_full_next; // Address captured, not yet used
   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic w_full_reg, w_full_next; // Data captured, not yet used
   logic [DATA_W-1:0] w_data_reg, w_data_next;
   logic [STRB_W-1:0] w_strb_reg, w_strb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   // Read channel state
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   // Interrupt registers
   logic [DATA_W-1:0] stat_reg, stat_next;
   logic [DATA_W-1:0] en_reg, en_next;
   logic irq_reg, irq_next;
   // Helpers
   logic do_write; // Both halves present and response slot free
   logic ar_take;
   logic [1:0] wr_sel;
   logic [1:0] rd_sel;
   logic [DATA_W-1:0] clear_mask; // Bits that software clears this cycle
   logic [DATA_W-1:0] fire_vec; // Client events this cycle
   logic [DATA_W-1:0] default_vec; // Clients still on their default event

   // Per-client event selectors; reserved positions never fire
   for (genvar i = 0; i < DATA_W; i++) begin : g_client
      if (CLIENT_MASK[i]) begin : g_live
         vci_event_select #(
            .DEFAULT_RX(RX_DEFAULT_MASK[i])
         ) u_sel (
            .clk(clk),
            .reset_n(reset_n),
            .cfg_load(descriptor.valid && (descriptor.client == 5'(i))),
            .cfg_sel(descriptor.sel),
            .eof_rx(client_events.eof_rx[i]),
            .eof_tx(client_events.eof_tx[i]),
            .alt(client_events.alt[i]),
            .fire(fire_vec[i]),
            .is_default(default_vec[i])
         );
      end else begin : g_rsvd
         assign fire_vec[i] = 1'b0;
         assign default_vec[i] = 1'b0;
      end
   end

   // Bus write path: address and data are taken in either order
   always_comb begin
      do_write = aw_full_reg && w_full_reg && !bvalid_reg;
      wr_sel = reg_select(aw_addr_reg);
      aw_full_next = aw_full_reg ? !do_write : (s_axi_awvalid && awready_reg);
      w_full_next = w_full_reg ? !do_write : (s_axi_wvalid && wready_reg);
      aw_addr_next = (!aw_full_reg && s_axi_awvalid) ? s_axi_awaddr : aw_addr_reg;
      w_data_next = (!w_full_reg && s_axi_wvalid) ? s_axi_wdata : w_data_reg;
      w_strb_next = (!w_full_reg && s_axi_wvalid) ? s_axi_wstrb : w_strb_reg;
      // Ready reopens only once the held item is used
      awready_next = !aw_full_next;
      wready_next = !w_full_next;
      bvalid_next = do_write ? 1'b1 : (bvalid_reg && !s_axi_bready);
      // Unmapped addresses answer with an error and store nothing
      bresp_next = bresp_reg;
      if (do_write) begin
         bresp_next = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   // Bus read path: one outstanding read, data one cycle after the address
   always_comb begin
      ar_take = s_axi_arvalid && arready_reg;
      rd_sel = reg_select(s_axi_araddr);
      rvalid_next = ar_take ? 1'b1 : (rvalid_reg && !s_axi_rready);
      arready_next = !rvalid_next;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (ar_take) begin
         unique case (rd_sel)
            SEL_STAT: rdata_next = stat_reg & CLIENT_MASK;
            SEL_EN: rdata_next = en_reg & CLIENT_MASK;
            default: rdata_next = '0;
         endcase
         rresp_next = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   // Status and enable update; a new event wins over a same-cycle clear
   always_comb begin
      clear_mask = '0;
      en_next = en_reg;
      if (do_write && wr_sel == SEL_STAT) begin
         clear_mask = w_data_reg & strb_mask(w_strb_reg);
      end
      if (do_write && wr_sel == SEL_EN) begin
         en_next = ((w_data_reg & strb_mask(w_strb_reg))
                    | (en_reg & ~strb_mask(w_strb_reg))) & CLIENT_MASK;
      end
      stat_next = ((stat_reg & ~clear_mask) | fire_vec) & CLIENT_MASK;
      // One shared line for the whole group
      irq_next = |(stat_next & en_next);
   end

   // Register stage for all state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_full_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
         stat_reg <= STAT_RESET;
         en_reg <= EN_RESET;
         irq_reg <= 1'b0;
      end else begin
         aw_full_reg <= aw_full_next;
         aw_addr_reg <= aw_addr_next;
         w_full_reg <= w_full_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         stat_reg <= stat_next;
         en_reg <= en_next;
         irq_reg <= irq_next;
      end
   end

   // Outputs straight from flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign shared_irq_line_three = irq_reg;

   // Checks on the registered state and the event decode
   a_irq_any_enabled: assert property (@(posedge clk) disable iff (!reset_n)
      irq_reg == |(stat_reg & en_reg)) else $error("irq does not match status and enable");
   a_irq_masked_off: assert property (@(posedge clk) disable iff (!reset_n)
      (en_reg == '0) |-> !shared_irq_line_three) else $error("irq high with all enables low");
   a_stat_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      ((($past(stat_reg) & ~$past(clear_mask)) & ~stat_reg) == '0))
      else $error("status bit dropped without a clear");
   a_event_sets_bit: assert property (@(posedge clk) disable iff (!reset_n)
      (fire_vec != '0) |=> ((stat_reg & $past(fire_vec)) == $past(fire_vec)))
      else $error("client event did not set status");
   a_clear_only_ones: assert property (@(posedge clk) disable iff (!reset_n)
      (do_write && wr_sel == SEL_STAT && fire_vec == '0)
      |=> (stat_reg == ($past(stat_reg) & ~($past(w_data_reg) & strb_mask($past(w_strb_reg))))))
      else $error("status clear touched wrong bits");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
      ((stat_reg | en_reg) & ~CLIENT_MASK) == '0) else $error("reserved bit set");
   a_enable_reset: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(reset_n) |-> (en_reg == EN_RESET && stat_reg == STAT_RESET))
      else $error("registers not cleared by reset");
   a_default_rx_event: assert property (@(posedge clk) disable iff (!reset_n)
      ((default_vec & RX_DEFAULT_MASK & client_events.eof_rx) & ~fire_vec) == '0)
      else $error("default received end-of-frame missed");
   a_default_tx_event: assert property (@(posedge clk) disable iff (!reset_n)
      ((default_vec & TX_DEFAULT_MASK & client_events.eof_tx) & ~fire_vec) == '0)
      else $error("default issued end-of-frame missed");
   // Only the two mapped offsets answer OKAY; anything else is refused
   a_write_answered: assert property (@(posedge clk) disable iff (!reset_n)
      do_write |=> s_axi_bvalid
      && (s_axi_bresp == (($past(wr_sel) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY)))
      else $error("write response missing or wrong");

   c_irq_rise: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq_reg));
   c_status_clear: cover property (@(posedge clk) disable iff (!reset_n)
      do_write && wr_sel == SEL_STAT && clear_mask != '0);
   c_set_beats_clear: cover property (@(posedge clk) disable iff (!reset_n)
      (clear_mask & fire_vec) != '0);
   c_descriptor_load: cover property (@(posedge clk) disable iff (!reset_n)
      descriptor.valid && descriptor.sel != EV_DEFAULT);

endmodule : vci_irq_status_mask

/* File: rtl/vci_pkg.sv */
// Operation
// - Status bit sets on client's selected event
// - Unconfigured output/capture clients: end-of-frame received
// - Unconfigured input/graphics clients: end-of-frame issued
// - Set status bit holds until software clears
// - Writing one clears; zero leaves bit
// - Enable bit gates its event onto output
// - Enable register at 0x174, resets zero
// - All client events share one output
// - Status at 0x170, resets zero, 31:30 zero
package vci_pkg;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // Register offsets and reset values
   localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h170;
   localparam logic [ADDR_W-1:0] EN_OFFSET = 12'h174;
   localparam logic [DATA_W-1:0] STAT_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] EN_RESET = 32'h0000_0000;

   // Implemented client positions; bits 31:30 and 18 are reserved
   localparam logic [DATA_W-1:0] CLIENT_MASK = 32'h3ffb_ffff;
   // Clients whose default event is end-of-frame received from the sender
   localparam logic [DATA_W-1:0] RX_DEFAULT_MASK = 32'h3c23_03fc;
   // Clients whose default event is end-of-frame issued to the receiver
   localparam logic [DATA_W-1:0] TX_DEFAULT_MASK = 32'h03d8_fc03;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Event chosen by a control descriptor, one-hot
   typedef enum logic [3:0] {
      EV_DEFAULT = 4'h1,
      EV_EOF_RX = 4'h2,
      EV_EOF_TX = 4'h4,
      EV_ALT = 4'h8
   } vci_event_sel_t;

   // Control descriptor arriving for one client
   typedef struct packed {
      logic valid;
      logic [4:0] client;
      vci_event_sel_t sel;
   } vci_descriptor_t;

   // Per-client event strobes from the video modules
   typedef struct packed {
      logic [DATA_W-1:0] eof_rx;
      logic [DATA_W-1:0] eof_tx;
      logic [DATA_W-1:0] alt;
   } vci_events_t;

endpackage : vci_pkg

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
// Bench for the client interrupt status and enable block
module tb_top;
   import vci_pkg::*;
   // Row: events and enable in, expected status and line out
   typedef struct {
      logic [31:0] rx, tx, alt, en, stat;
      logic irq;
   } vci_row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [STRB_W-1:0] wstrb = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   logic [DATA_W-1:0] rdata, word;
   vci_descriptor_t descriptor;
   vci_events_t client_events;
   int n_mismatch = 0;
   int comparisons = 0;
   // Masks are disjoint, so swapping them must set nothing
   vci_row_t rows [5] = '{
      '{RX_DEFAULT_MASK, 32'h0, 32'h0, 32'h0, RX_DEFAULT_MASK, 1'b0},
      '{32'h0, TX_DEFAULT_MASK, 32'h0, 32'h0000_0001, TX_DEFAULT_MASK, 1'b1},
      '{TX_DEFAULT_MASK, RX_DEFAULT_MASK, 32'h0, 32'hffff_ffff, 32'h0, 1'b0},
      '{32'h0, 32'h0, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 1'b0},
      '{32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'h0002_0000, CLIENT_MASK, 1'b1}};
   vci_event_sel_t sels [4] = '{EV_DEFAULT, EV_EOF_RX, EV_EOF_TX, EV_ALT};
   // Which of rx, tx, alt (bits 0..2) fires client 2 in each mode
   logic [2:0] hits [4] = '{3'b001, 3'b001, 3'b010, 3'b100};

   initial begin
      forever #2 clk = ~clk;
   end

   vci_irq_status_mask vci_irq_status_mask_i (
      .clk(clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .descriptor(descriptor),
      .client_events(client_events), .shared_irq_line_three(irq));

   vci_video_model vci_video_model_i (
      .clk(clk), .descriptor(descriptor), .client_events(client_events));

   // Case equality so an unknown never passes
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t irq %b expected %b", $time, got, exp);
      end
   endtask : check_bit

   // Address and data offered together, each dropped once taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      word = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_read

   task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] r);
      axi_read(a);
      check_word(word, exp);
      check_word({30'h0, resp}, {30'h0, r});
   endtask : chk_reg

   task automatic do_reset();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
   endtask : do_reset

   task automatic print_verdict();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // Whole run needs a few hundred cycles
   initial begin
      #200000;
      n_mismatch++;
      $display("CHECK FAILED %0t run hung", $time);
      print_verdict();
   end

   initial begin
      do_reset();
      chk_reg(STAT_OFFSET, STAT_RESET, RESP_OKAY);
      chk_reg(EN_OFFSET, EN_RESET, RESP_OKAY);
      foreach (rows[i]) begin
         axi_write(EN_OFFSET, rows[i].en, 4'hf);
         chk_reg(EN_OFFSET, rows[i].en & CLIENT_MASK, RESP_OKAY);
         vci_video_model_i.pulse_events({rows[i].rx, rows[i].tx, rows[i].alt});
         chk_reg(STAT_OFFSET, rows[i].stat, RESP_OKAY);
         check_bit(irq, rows[i].irq);
         axi_write(STAT_OFFSET, 32'hffff_ffff, 4'hf);
         chk_reg(STAT_OFFSET, 32'h0, RESP_OKAY);
         check_bit(irq, 1'b0);
      end
      // Later wrong-kind events and zero writes must not disturb set bits
      axi_write(EN_OFFSET, 32'h0000_0008, 4'hf);
      vci_video_model_i.pulse_events({32'h0000_020c, 64'h0});
      vci_video_model_i.pulse_events({32'h0, 32'h0000_020c, 32'h0000_020c});
      chk_reg(STAT_OFFSET, 32'h0000_020c, RESP_OKAY);
      axi_write(STAT_OFFSET, 32'h0000_0004, 4'hf);
      chk_reg(STAT_OFFSET, 32'h0000_0208, RESP_OKAY);
      axi_write(STAT_OFFSET, 32'hffff_ffff, 4'h2);
      chk_reg(STAT_OFFSET, 32'h0000_0008, RESP_OKAY);
      axi_write(STAT_OFFSET, 32'h0, 4'hf);
      chk_reg(STAT_OFFSET, 32'h0000_0008, RESP_OKAY);
      check_bit(irq, 1'b1);
      axi_write(STAT_OFFSET, 32'h0000_0008, 4'hf);
      // Every selection mode against every kind of event on client 2
      foreach (sels[m]) begin
         vci_video_model_i.send_desc(5'd2, sels[m]);
         for (int k = 0; k < 3; k++) begin
            vci_video_model_i.pulse_events(96'h4 << (32 * (2 - k)));
            chk_reg(STAT_OFFSET, hits[m][k] ? 32'h4 : 32'h0, RESP_OKAY);
            axi_write(STAT_OFFSET, 32'h4, 4'h1);
         end
      end
      // A code that is not one-hot leaves the client silent
      vci_video_model_i.send_desc(5'd2, vci_event_sel_t'(4'h3));
      vci_video_model_i.pulse_events({32'h4, 32'h4, 32'h4});
      chk_reg(STAT_OFFSET, 32'h0, RESP_OKAY);
      // Unmapped place: write ignored, read gives zero, both refused
      axi_write(12'h100, 32'hffff_ffff, 4'hf);
      check_word({30'h0, resp}, {30'h0, RESP_SLVERR});
      chk_reg(12'h100, 32'h0, RESP_SLVERR);
      // Reset in mid-run drops the raised line and both registers
      axi_write(EN_OFFSET, 32'hffff_ffff, 4'hf);
      vci_video_model_i.pulse_events({32'h8, 64'h0});
      // Line registers at the edge that samples the pulse; look one edge later
      @(posedge clk);
      check_bit(irq, 1'b1);
      do_reset();
      check_bit(irq, 1'b0);
      chk_reg(STAT_OFFSET, STAT_RESET, RESP_OKAY);
      chk_reg(EN_OFFSET, EN_RESET, RESP_OKAY);
      // Reset also returns client 2 to its default received end-of-frame
      vci_video_model_i.pulse_events({32'h4, 64'h0});
      chk_reg(STAT_OFFSET, 32'h4, RESP_OKAY);
      print_verdict();
   end
endmodule : tb_top

/* File: tb/vci_video_model.sv */
`timescale 1ns/100ps
// Stands in for the video modules feeding the interrupt block
module vci_video_model (
   input wire logic clk,
   output vci_pkg::vci_descriptor_t descriptor,
   output vci_pkg::vci_events_t client_events
);
   import vci_pkg::*;

   // Quiet outputs from time zero
   initial begin
      descriptor = '0;
      client_events = '0;
   end

   // One-cycle event pulses; a held level would set status every cycle
   task automatic pulse_events(input logic [95:0] ev);
      @(posedge clk);
      client_events <= ev;
      @(posedge clk);
      client_events <= '0;
   endtask : pulse_events

   // Picks the event that a client reports from now on
   task automatic send_desc(input logic [4:0] client, input vci_event_sel_t sel);
      @(posedge clk);
      descriptor <= '{valid: 1'b1, client: client, sel: sel};
      @(posedge clk);
      descriptor <= '0;
   endtask : send_desc
endmodule : vci_video_model
